// ===== hdl/crs_alu.v
// arithmetic unit producing a result and flag candidates.
// assumes the caller latches flags; purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "crs_map.vh"

module crs_alu
(
	input  wire [2:0] kind_i,
	input  wire [7:0] a_i,
	input  wire [7:0] b_i,
	input  wire       carry_i,
	output reg  [7:0] res_o,
	output reg        half_o,
	output reg        carry_o
);
	reg [8:0] sum;
	reg [4:0] low;

	always @*
	begin
		sum = 9'h000;
		low = 5'h00;
		res_o = b_i;
		half_o = 1'b0;
		carry_o = carry_i;
		case (kind_i)
			`CRS_ALU_ADD, `CRS_ALU_ADC:
			begin
				sum = {1'b0, a_i} + {1'b0, b_i}
					+ {8'h00, (kind_i == `CRS_ALU_ADC) & carry_i};
				low = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]}
					+ {4'h0, (kind_i == `CRS_ALU_ADC) & carry_i};
				res_o = sum[7:0];
				half_o = low[4];
				carry_o = sum[8];
			end
			`CRS_ALU_SUB:
			begin
				sum = {1'b0, a_i} - {1'b0, b_i};
				res_o = sum[7:0];
				carry_o = sum[8];
			end
			`CRS_ALU_SHIFT:
			begin
				res_o = {b_i[6:0], carry_i};
				carry_o = b_i[7];
			end
			`CRS_ALU_BTEST:
			begin
				res_o = a_i;
				carry_o = |(a_i & b_i);
			end
			default:
			begin
				res_o = b_i;
			end
		endcase
	end
endmodule
`default_nettype wire

// ===== hdl/crs_core_regs.v
// architectural register set of an 8-bit core: working, index, fetch
// pointer, flags and wrapping stack pointer, with stack write/read sequencing.
// assumes the sequencer issues one op at a time and waits while busy_o.
`timescale 1ns/1ps
`default_nettype none
`include "crs_map.vh"

// Behaviour
// - 8-bit working register, instruction access only
// - second index register never stacked on interrupt
// - 16-bit fetch pointer, low and high bytes
// - flags reset with bits 7-5 and mask set
// - bit 4 records carry out of bit 3
// - mask set on interrupt entry or software
// - requests held pending while mask is set
// - handler return clears mask; clearing releases pending requests
// - bit 2 copies result's top bit
// - bit 1 set when result is zero
// - carry from arithmetic, forced ops, shifts, bit-tests
// - stack pointer post-decrements on push, pre-increments pop
// - upper nine bits fixed; reload sets low seven
// - stack pointer wraps silently both directions
// - call two bytes, interrupt five, low byte first
// - stack pointer low seven bits loadable directly
// - reset loads fetch pointer from vector bytes
// - interrupt saves pointer, index, working, flags
module crs_core_regs
(
	input  wire        clk_sys_i,
	input  wire        rst_n_i,
	input  wire [3:0]  op_i,
	input  wire [2:0]  alu_kind_i,
	input  wire [7:0]  operand_i,
	input  wire [15:0] addr_i,
	input  wire        index_x_load_i,
	input  wire        index_y_load_i,
	input  wire        irq_req_i,
	input  wire [7:0]  mem_rdata_i,
	output reg  [15:0] mem_addr_o,
	output reg  [7:0]  mem_wdata_o,
	output reg         mem_we_o,
	output reg         mem_re_o,
	output reg         busy_o,
	output reg         irq_take_o,
	output reg  [7:0]  working_o,
	output reg  [7:0]  index_x_o,
	output reg  [7:0]  index_y_o,
	output reg  [15:0] next_fetch_pointer_o,
	output reg  [7:0]  flag_register_o,
	output reg  [15:0] stack_top_o
);
	localparam [6:0] ST_VEC_LO = 7'h01;
	localparam [6:0] ST_VEC_HI = 7'h02;
	localparam [6:0] ST_IDLE   = 7'h04;
	localparam [6:0] ST_PUSH   = 7'h08;
	localparam [6:0] ST_POPA   = 7'h10;
	localparam [6:0] ST_POPD   = 7'h20;
	localparam [6:0] ST_VEC_W  = 7'h40;

	reg        rst_meta_reg;
	reg        rst_sync_reg;
	reg        irq_meta_reg;
	reg        irq_sync_reg;
	wire       rst_n;

	reg [6:0]  state_reg;
	reg [6:0]  state_next;
	reg [7:0]  working_reg;
	reg [7:0]  working_next;
	reg [7:0]  index_x_reg;
	reg [7:0]  index_x_next;
	reg [7:0]  index_y_reg;
	reg [15:0] fetch_reg;
	reg [15:0] fetch_next;
	reg [7:0]  flag_reg;
	reg [7:0]  flag_next;
	reg [6:0]  sp_low_reg;
	reg [6:0]  sp_low_next;
	reg [2:0]  cnt_reg;
	reg [2:0]  cnt_next;
	reg [2:0]  len_reg;
	reg [2:0]  len_next;
	reg        pend_reg;
	reg        pend_next;
	reg        is_irq_reg;
	reg        is_irq_next;
	reg [15:0] mem_addr_next;
	reg [7:0]  mem_wdata_next;
	reg        mem_we_next;
	reg        mem_re_next;
	reg        take_next;

	wire [7:0] alu_res;
	wire       alu_half;
	wire       alu_carry;

	// full stack address from the seven live bits
	function [15:0] sp_addr;
		input [6:0] low;
		begin
			sp_addr = `CRS_SP_FIXED | {9'h000, low};
		end
	endfunction

	// context byte k of the interrupt frame (0 is written first)
	function [7:0] ctx_byte;
		input [2:0]  k;
		input [15:0] pc;
		input [7:0]  x;
		input [7:0]  a;
		input [7:0]  f;
		begin
			case (k)
				3'h0: ctx_byte = pc[7:0];
				3'h1: ctx_byte = pc[15:8];
				3'h2: ctx_byte = x;
				3'h3: ctx_byte = a;
				default: ctx_byte = f;
			endcase
		end
	endfunction

	assign rst_n = rst_sync_reg;

	crs_alu u_alu
	(
		.kind_i  (alu_kind_i),
		.a_i     (working_reg),
		.b_i     (operand_i),
		.carry_i (flag_reg[`CRS_FLAG_C]),
		.res_o   (alu_res),
		.half_o  (alu_half),
		.carry_o (alu_carry)
	);

	always @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	always @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_meta_reg <= 1'b0;
			irq_sync_reg <= 1'b0;
		end
		else
		begin
			irq_meta_reg <= irq_req_i;
			irq_sync_reg <= irq_meta_reg;
		end
	end

	always @*
	begin
		state_next = state_reg;
		working_next = working_reg;
		index_x_next = index_x_reg;
		fetch_next = fetch_reg;
		flag_next = flag_reg;
		sp_low_next = sp_low_reg;
		cnt_next = cnt_reg;
		len_next = len_reg;
		is_irq_next = is_irq_reg;
		mem_addr_next = sp_addr(sp_low_reg);
		mem_wdata_next = 8'h00;
		mem_we_next = 1'b0;
		mem_re_next = 1'b0;
		take_next = 1'b0;
		pend_next = pend_reg | irq_sync_reg;
		if (index_x_load_i)
			index_x_next = operand_i;
		case (state_reg)
			ST_VEC_LO:
			begin
				mem_addr_next = `CRS_VEC_LO;
				mem_re_next = 1'b1;
				state_next = ST_VEC_HI;
			end
			ST_VEC_HI:
			begin
				mem_addr_next = `CRS_VEC_HI;
				mem_re_next = 1'b1;
				fetch_next[15:8] = mem_rdata_i;
				state_next = ST_VEC_W;
			end
			ST_VEC_W:
			begin
				fetch_next[7:0] = mem_rdata_i;
				state_next = ST_IDLE;
			end
			ST_PUSH:
			begin
				mem_we_next = 1'b1;
				mem_addr_next = sp_addr(sp_low_reg);
				mem_wdata_next = ctx_byte(cnt_reg, fetch_reg, index_x_reg,
					working_reg, flag_reg);
				sp_low_next = sp_low_reg - 7'h01;
				cnt_next = cnt_reg + 3'h1;
				if (cnt_reg + 3'h1 == len_reg)
				begin
					state_next = ST_IDLE;
					if (is_irq_reg)
					begin
						flag_next[`CRS_FLAG_I] = 1'b1;
						fetch_next = addr_i;
					end
				end
			end
			ST_POPA:
			begin
				sp_low_next = sp_low_reg + 7'h01;
				mem_addr_next = sp_addr(sp_low_reg + 7'h01);
				mem_re_next = 1'b1;
				state_next = ST_POPD;
			end
			ST_POPD:
			begin
				// bytes come back in reverse of the push order
				if (is_irq_reg)
				begin
					case (cnt_reg)
						3'h4: flag_next = mem_rdata_i | `CRS_FLAG_FIXED;
						3'h3: working_next = mem_rdata_i;
						3'h2: index_x_next = mem_rdata_i;
						3'h1: fetch_next[15:8] = mem_rdata_i;
						default: fetch_next[7:0] = mem_rdata_i;
					endcase
				end
				else if (cnt_reg == 3'h1)
					fetch_next[15:8] = mem_rdata_i;
				else
					fetch_next[7:0] = mem_rdata_i;
				if (cnt_reg == 3'h0)
				begin
					state_next = ST_IDLE;
					if (is_irq_reg)
						flag_next[`CRS_FLAG_I] = 1'b0;
				end
				else
				begin
					cnt_next = cnt_reg - 3'h1;
					state_next = ST_POPA;
				end
			end
			default:
			begin
				if (pend_reg && !flag_reg[`CRS_FLAG_I] && op_i == `CRS_OP_NONE)
				begin
					// a new request in the same cycle stays pending
					pend_next = irq_sync_reg;
					take_next = 1'b1;
					is_irq_next = 1'b1;
					len_next = 3'h5;
					cnt_next = 3'h0;
					state_next = ST_PUSH;
				end
				else
				begin
					case (op_i)
						`CRS_OP_ALU:
						begin
							working_next = alu_res;
							if (alu_kind_i == `CRS_ALU_ADD || alu_kind_i == `CRS_ALU_ADC)
								flag_next[`CRS_FLAG_HBIT] = alu_half;
							flag_next[`CRS_FLAG_N] = alu_res[7];
							flag_next[`CRS_FLAG_Z] = (alu_res == 8'h00);
							if (alu_kind_i != `CRS_ALU_LOGIC)
								flag_next[`CRS_FLAG_C] = alu_carry;
							if (alu_kind_i == `CRS_ALU_BTEST)
								working_next = working_reg;
						end
						`CRS_OP_SET_CARRY: flag_next[`CRS_FLAG_C] = 1'b1;
						`CRS_OP_CLR_CARRY: flag_next[`CRS_FLAG_C] = 1'b0;
						`CRS_OP_SET_MASK: flag_next[`CRS_FLAG_I] = 1'b1;
						`CRS_OP_CLR_MASK: flag_next[`CRS_FLAG_I] = 1'b0;
						`CRS_OP_SP_RELOAD: sp_low_next = `CRS_SP_LOW_MASK;
						`CRS_OP_SP_LOAD: sp_low_next = operand_i[6:0];
						`CRS_OP_FLAG_LOAD: flag_next = operand_i | `CRS_FLAG_FIXED;
						`CRS_OP_CALL:
						begin
							is_irq_next = 1'b0;
							len_next = 3'h2;
							cnt_next = 3'h0;
							state_next = ST_PUSH;
							fetch_next = fetch_reg;
						end
						`CRS_OP_RET:
						begin
							is_irq_next = 1'b0;
							cnt_next = 3'h1;
							state_next = ST_POPA;
						end
						`CRS_OP_RET_HANDLER:
						begin
							is_irq_next = 1'b1;
							cnt_next = 3'h4;
							state_next = ST_POPA;
						end
						`CRS_OP_PC_LOAD: fetch_next = addr_i;
						`CRS_OP_PC_STEP: fetch_next = fetch_reg + 16'h0001;
						`CRS_OP_WORK_LOAD: working_next = operand_i;
						default: fetch_next = fetch_reg;
					endcase
				end
			end
		endcase
		// call target loads after the frame is written
		if (state_reg == ST_PUSH && !is_irq_reg && cnt_reg + 3'h1 == len_reg)
			fetch_next = addr_i;
	end

	always @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= ST_VEC_LO;
			working_reg <= 8'h00;
			index_x_reg <= 8'h00;
			index_y_reg <= 8'h00;
			fetch_reg <= 16'h0000;
			flag_reg <= `CRS_FLAG_RST;
			sp_low_reg <= `CRS_SP_LOW_MASK;
			cnt_reg <= 3'h0;
			len_reg <= 3'h0;
			pend_reg <= 1'b0;
			is_irq_reg <= 1'b0;
			mem_addr_o <= 16'h0000;
			mem_wdata_o <= 8'h00;
			mem_we_o <= 1'b0;
			mem_re_o <= 1'b0;
			busy_o <= 1'b1;
			irq_take_o <= 1'b0;
			working_o <= 8'h00;
			index_x_o <= 8'h00;
			index_y_o <= 8'h00;
			next_fetch_pointer_o <= 16'h0000;
			flag_register_o <= `CRS_FLAG_RST;
			stack_top_o <= `CRS_SP_RST;
		end
		else
		begin
			state_reg <= state_next;
			working_reg <= working_next;
			index_x_reg <= index_x_next;
			if (index_y_load_i)
				index_y_reg <= operand_i;
			fetch_reg <= fetch_next;
			flag_reg <= flag_next;
			sp_low_reg <= sp_low_next;
			cnt_reg <= cnt_next;
			len_reg <= len_next;
			pend_reg <= pend_next;
			is_irq_reg <= is_irq_next;
			mem_addr_o <= mem_addr_next;
			mem_wdata_o <= mem_wdata_next;
			mem_we_o <= mem_we_next;
			mem_re_o <= mem_re_next;
			busy_o <= (state_next != ST_IDLE);
			irq_take_o <= take_next;
			working_o <= working_next;
			index_x_o <= index_x_next;
			index_y_o <= index_y_load_i ? operand_i : index_y_reg;
			next_fetch_pointer_o <= fetch_next;
			flag_register_o <= flag_next;
			stack_top_o <= sp_addr(sp_low_next);
		end
	end
endmodule
`default_nettype wire

// ===== hdl/crs_map.vh
// constants for the core register set: reset values, flag bit positions,
// stack limits, vector addresses and operation codes of the control port.
`ifndef CRS_MAP_VH
`define CRS_MAP_VH

`define CRS_FLAG_H          4
`define CRS_FLAG_I          3
`define CRS_FLAG_N          2
`define CRS_FLAG_Z          1
`define CRS_FLAG_C          0
`define CRS_FLAG_HBIT       4
`define CRS_FLAG_RST        8'he8
`define CRS_FLAG_FIXED      8'he0
`define CRS_SP_RST          16'h017f
`define CRS_SP_FIXED        16'h0100
`define CRS_SP_LOW_MASK     7'h7f
`define CRS_VEC_LO          16'hfffe
`define CRS_VEC_HI          16'hffff

// register-op codes
`define CRS_OP_NONE         4'h0
`define CRS_OP_ALU          4'h1
`define CRS_OP_SET_CARRY    4'h2
`define CRS_OP_CLR_CARRY    4'h3
`define CRS_OP_SET_MASK     4'h4
`define CRS_OP_CLR_MASK     4'h5
`define CRS_OP_SP_RELOAD    4'h6
`define CRS_OP_SP_LOAD      4'h7
`define CRS_OP_FLAG_LOAD    4'h8
`define CRS_OP_CALL         4'h9
`define CRS_OP_RET          4'ha
`define CRS_OP_INT_ENTER    4'hb
`define CRS_OP_RET_HANDLER  4'hc
`define CRS_OP_PC_LOAD      4'hd
`define CRS_OP_PC_STEP      4'he
`define CRS_OP_WORK_LOAD    4'hf

// alu kinds
`define CRS_ALU_ADD         3'h0
`define CRS_ALU_ADC         3'h1
`define CRS_ALU_SUB         3'h2
`define CRS_ALU_LOGIC       3'h3
`define CRS_ALU_SHIFT       3'h4
`define CRS_ALU_BTEST       3'h5

`endif

// ===== tb/crs_core_regs_checker.sv
// checker for the core register set, seeing only the top module's ports.
// assumes clk_sys_i is the only clock and rst_n_i clears all state.
`timescale 1ns/1ps
`default_nettype none
`include "crs_map.vh"
module crs_core_regs_checker
(
	input wire        clk_sys_i,
	input wire        rst_n_i,
	input wire [3:0]  op_i,
	input wire        busy_o,
	input wire        irq_take_o,
	input wire        mem_we_o,
	input wire [15:0] mem_addr_o,
	input wire [7:0]  mem_wdata_o,
	input wire [7:0]  flag_register_o,
	input wire [15:0] next_fetch_pointer_o,
	input wire [15:0] stack_top_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	AST_SP_HIGH: assert property (stack_top_o[15:7] == 9'h002)
		else $error("stack pointer upper bits moved");
	AST_FLAG_FIXED: assert property (flag_register_o[7:5] == 3'h7)
		else $error("flag bits 7 to 5 not one");
	AST_IRQ_MASK: assert property (irq_take_o |-> ##[1:8] flag_register_o[3])
		else $error("mask not set on interrupt entry");
	AST_IRQ_PUSHES: assert property (irq_take_o |=> mem_we_o [*5])
		else $error("interrupt frame not five writes");
	AST_IRQ_FIRST: assert property (irq_take_o |=> mem_addr_o == $past(stack_top_o)
		&& mem_wdata_o == $past(next_fetch_pointer_o[7:0]))
		else $error("interrupt frame does not start with pointer low byte");
	AST_IRQ_UNMASKED: assert property (irq_take_o |-> !$past(flag_register_o[3]))
		else $error("interrupt taken while masked");
	AST_PUSH_DOWN: assert property (mem_we_o && $past(mem_we_o)
		|-> mem_addr_o == {9'h002, $past(mem_addr_o[6:0]) - 7'h01})
		else $error("push address not one below previous");
	AST_CLR_CARRY: assert property (!busy_o && op_i == `CRS_OP_CLR_CARRY
		|=> !flag_register_o[0])
		else $error("carry not cleared");
	AST_SET_MASK: assert property (!busy_o && op_i == `CRS_OP_SET_MASK |=> flag_register_o[3])
		else $error("mask not set by software");
	AST_RELOAD: assert property (!busy_o && op_i == `CRS_OP_SP_RELOAD
		|=> stack_top_o == 16'h017f)
		else $error("stack reload wrong");
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for crs_core_regs driving its control port directly.
// assumes a byte memory whose read data stands while mem_re_o is high.
`timescale 1ns/1ps
`default_nettype none
`include "crs_map.vh"
`define CHK(a, e) begin n_checks = n_checks + 1; if ((a) !== (e)) begin \
	err_count = err_count + 1; $display("unexpected at %0t: %h vs %h", $time, a, e); end end
module tb;
	reg         clk_sys_i = 1'b0;
	reg         rst_n_i = 1'b0;
	reg  [3:0]  op_i = 4'h0;
	reg  [2:0]  alu_kind_i = 3'h0;
	reg  [7:0]  operand_i = 8'h00;
	reg  [15:0] addr_i = 16'h0000;
	reg         index_x_load_i = 1'b0;
	reg         index_y_load_i = 1'b0;
	reg         irq_req_i = 1'b0;
	wire [7:0]  mem_rdata_i;
	wire [15:0] mem_addr_o;
	wire [7:0]  mem_wdata_o;
	wire        mem_we_o;
	wire        mem_re_o;
	wire        busy_o;
	wire        irq_take_o;
	wire [7:0]  working_o;
	wire [7:0]  index_x_o;
	wire [7:0]  index_y_o;
	wire [15:0] next_fetch_pointer_o;
	wire [7:0]  flag_register_o;
	wire [15:0] stack_top_o;
	reg  [7:0]  mem [0:511];
	integer     err_count = 0;
	integer     n_checks = 0;
	integer     cycles = 0;
	crs_core_regs i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .op_i(op_i),
		.alu_kind_i(alu_kind_i), .operand_i(operand_i), .addr_i(addr_i),
		.index_x_load_i(index_x_load_i), .index_y_load_i(index_y_load_i),
		.irq_req_i(irq_req_i), .mem_rdata_i(mem_rdata_i), .mem_addr_o(mem_addr_o),
		.mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o), .mem_re_o(mem_re_o),
		.busy_o(busy_o), .irq_take_o(irq_take_o), .working_o(working_o),
		.index_x_o(index_x_o), .index_y_o(index_y_o),
		.next_fetch_pointer_o(next_fetch_pointer_o),
		.flag_register_o(flag_register_o), .stack_top_o(stack_top_o));
	always #2.5 clk_sys_i = ~clk_sys_i;
	// stack memory plus the two vector bytes
	always @(posedge clk_sys_i)
	begin
		if (mem_we_o)
			mem[mem_addr_o[8:0]] <= mem_wdata_o;
	end
	// read data is taken by the design at the edge that ends the cycle its address is on mem_addr_o
	assign mem_rdata_i = !mem_re_o ? 8'h00 : (mem_addr_o == 16'hfffe) ? 8'h12 :
		(mem_addr_o == 16'hffff) ? 8'h34 : mem[mem_addr_o[8:0]];
	task end_sim;
	begin
		if (err_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask
	always @(posedge clk_sys_i)
	begin
		cycles = cycles + 1;
		if (cycles == 3000)
		begin
			err_count = err_count + 1;
			end_sim;
		end
	end
	task wait_idle;
		integer k;
	begin
		k = 0;
		#1;
		while (busy_o !== 1'b0 && k < 40)
		begin
			@(posedge clk_sys_i);
			#1;
			k = k + 1;
		end
	end
	endtask
	task op(input [3:0] c, input [2:0] kd, input [7:0] d, input [15:0] a);
	begin
		@(posedge clk_sys_i);
		op_i <= c;
		alu_kind_i <= kd;
		operand_i <= d;
		addr_i <= a;
		@(posedge clk_sys_i);
		op_i <= `CRS_OP_NONE;
		wait_idle;
	end
	endtask
	task idx(input y, input [7:0] d);
	begin
		@(posedge clk_sys_i);
		operand_i <= d;
		index_x_load_i <= !y;
		index_y_load_i <= y;
		@(posedge clk_sys_i);
		index_x_load_i <= 1'b0;
		index_y_load_i <= 1'b0;
	end
	endtask
	task add(input [7:0] d, input [7:0] r, input [4:0] f);
	begin
		op(`CRS_OP_ALU, `CRS_ALU_ADD, d, 16'h0000);
		`CHK(working_o, r)
		`CHK({flag_register_o[4], flag_register_o[2:0]}, {f[4], f[2:0]})
	end
	endtask
	initial
	begin
		repeat (12) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		wait_idle;
		`CHK(next_fetch_pointer_o, 16'h1234)
		`CHK({flag_register_o[7:5], flag_register_o[3]}, 4'hf)
		`CHK(stack_top_o, 16'h017f)
		op(`CRS_OP_WORK_LOAD, 3'h0, 8'h0f, 16'h0000);
		add(8'h01, 8'h10, 5'h10);
		add(8'hf0, 8'h00, 5'h03);
		add(8'h80, 8'h80, 5'h04);
		op(`CRS_OP_CLR_CARRY, 3'h0, 8'h00, 16'h0000);
		`CHK(flag_register_o[0], 1'b0)
		op(`CRS_OP_SET_CARRY, 3'h0, 8'h00, 16'h0000);
		`CHK(flag_register_o[0], 1'b1)
		op(`CRS_OP_FLAG_LOAD, 3'h0, 8'h00, 16'h0000);
		`CHK(flag_register_o, 8'he0)
		op(`CRS_OP_PC_LOAD, 3'h0, 8'h00, 16'h4321);
		`CHK(next_fetch_pointer_o, 16'h4321)
		op(`CRS_OP_SP_LOAD, 3'h0, 8'h81, 16'h0000);
		`CHK(stack_top_o, 16'h0101)
		op(`CRS_OP_CALL, 3'h0, 8'h00, 16'h2000);
		@(posedge clk_sys_i);
		#1;
		`CHK({mem[9'h101], mem[9'h100]}, 16'h2143)
		`CHK(stack_top_o, 16'h017f)
		`CHK(next_fetch_pointer_o, 16'h2000)
		op(`CRS_OP_RET, 3'h0, 8'h00, 16'h0000);
		`CHK({stack_top_o, next_fetch_pointer_o}, 32'h01014321)
		idx(1'b1, 8'h5a);
		idx(1'b0, 8'ha5);
		op(`CRS_OP_SP_RELOAD, 3'h0, 8'h00, 16'h0000);
		op(`CRS_OP_SET_MASK, 3'h0, 8'h00, 16'h8000);
		@(posedge clk_sys_i);
		irq_req_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		irq_req_i <= 1'b0;
		repeat (10) @(posedge clk_sys_i);
		`CHK(stack_top_o, 16'h017f)
		op(`CRS_OP_CLR_MASK, 3'h0, 8'h00, 16'h8000);
		repeat (12) @(posedge clk_sys_i);
		wait_idle;
		`CHK(next_fetch_pointer_o, 16'h8000)
		`CHK(stack_top_o, 16'h017a)
		`CHK({mem[9'h17f], mem[9'h17e], mem[9'h17d]}, 24'h2143a5)
		`CHK({mem[9'h17c], mem[9'h17b]}, 16'h80e0)
		`CHK(flag_register_o[3], 1'b1)
		idx(1'b0, 8'h11);
		op(`CRS_OP_RET_HANDLER, 3'h0, 8'h00, 16'h0000);
		`CHK({index_x_o, index_y_o, working_o}, 24'ha55a80)
		`CHK({stack_top_o, next_fetch_pointer_o}, 32'h017f4321)
		`CHK(flag_register_o, 8'he0)
		op(`CRS_OP_PC_STEP, 3'h0, 8'h00, 16'h0000);
		`CHK(next_fetch_pointer_o, 16'h4322)
		op(`CRS_OP_ALU, `CRS_ALU_SUB, 8'h81, 16'h0000);
		`CHK({working_o, flag_register_o[2:0]}, 11'h7fd)
		op(`CRS_OP_ALU, `CRS_ALU_SHIFT, 8'h81, 16'h0000);
		`CHK({working_o, flag_register_o[2:0]}, 11'h019)
		op(`CRS_OP_ALU, `CRS_ALU_BTEST, 8'h04, 16'h0000);
		`CHK({working_o, flag_register_o[2:0]}, 11'h018)
		op(`CRS_OP_ALU, `CRS_ALU_LOGIC, 8'h00, 16'h0000);
		`CHK({working_o, flag_register_o[2:0]}, 11'h002)
		end_sim;
	end
endmodule
bind crs_core_regs crs_core_regs_checker i_chk (.clk_sys_i, .rst_n_i, .op_i, .busy_o,
	.irq_take_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .flag_register_o,
	.next_fetch_pointer_o, .stack_top_o);
`default_nettype wire
